//--- core/uvec_pkg.sv
// Purpose: Constants, types and helpers of the interrupt autovector block.
// Assumes: One clock, AXI4-Lite register access, 32-bit data words.
// Notes:   Rules follow.
// Function
// R1: Merge 27 USB events onto one USB request with a per-source vector.
// R2: USB interrupt entry sends the core to code address 0x0043.
// R3: With USB autovector on, the byte fetched at 0x0045 becomes the USB vector.
// R4: USB vector equals four times (priority rank minus one).
// R5: USB codes 00 to 18 for bus events, 1C reserved.
// R6: Endpoint buffer events use codes 20 through 3C.
// R7: IN NAK uses 40, ping NAKs 48 to 5C, 44 reserved.
// R8: Error limit 60, iso sequence errors 70 to 7C, 64 to 6C unused.
// R9: Merge 14 FIFO and waveform events onto a second request with autovector.
// R10: FIFO interrupt entry sends the core to code address 0x0053.
// R11: With FIFO autovector on, the byte fetched at 0x0055 becomes the FIFO vector.
// R12: Level flags use 80 to 8C, empty flags 90 to 9C.
// R13: Full flags A0 to AC, waveform done B0, waveform event B4.
// R14: With several pending, the vector names the best ranked source.
// R15: With autovector off, fetched bytes pass through unchanged.
package uvec_pkg;

  // Code addresses of the two interrupt entries and their jump operands.
  localparam logic [15:0] USB_ENTRY     = 16'h0043;
  localparam logic [15:0] USB_PAGE_ADDR = 16'h0044;
  localparam logic [15:0] USB_SUB_ADDR  = 16'h0045;
  localparam logic [15:0] FIFO_ENTRY    = 16'h0053;
  localparam logic [15:0] FIFO_PAGE_ADDR = 16'h0054;
  localparam logic [15:0] FIFO_SUB_ADDR = 16'h0055;

  // Vector bases and source counts.
  localparam logic [7:0]  USB_VEC_BASE  = 8'h00;
  localparam logic [7:0]  FIFO_VEC_BASE = 8'h80;
  localparam int          USB_SRC       = 27;
  localparam int          USB_RANKS     = 32;
  localparam int          FIFO_SRC      = 14;
  // Rank positions that carry a source; reserved ranks stay zero.
  localparam logic [31:0] USB_RANK_MASK = 32'hF1FD_FF7F;

  // Register byte offsets.
  localparam logic [7:0]  OFS_SETUP     = 8'h00;
  localparam logic [7:0]  OFS_USB_STAT  = 8'h04;
  localparam logic [7:0]  OFS_USB_EN    = 8'h08;
  localparam logic [7:0]  OFS_USB_CLR   = 8'h0C;
  localparam logic [7:0]  OFS_FIFO_STAT = 8'h10;
  localparam logic [7:0]  OFS_FIFO_EN   = 8'h14;
  localparam logic [7:0]  OFS_FIFO_CLR  = 8'h18;
  localparam logic [7:0]  OFS_VECTORS   = 8'h1C;

  // Setup register bit positions and reset values.
  localparam int          SETUP_USB_AV  = 0;
  localparam int          SETUP_FIFO_AV = 1;
  localparam logic [1:0]  SETUP_RST     = 2'h0;
  localparam logic [31:0] USB_EN_RST    = 32'h0000_0000;
  localparam logic [13:0] FIFO_EN_RST   = 14'h0000;

  // AXI response codes.
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } uvec_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } uvec_axi_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } uvec_fetch_t;

  // Places the 27 USB sources at their ranks, with gaps at reserved codes.
  function automatic logic [31:0] uvec_usb_rank_map(input logic [26:0] ev);
    return {ev[26:23], 3'b000, ev[22], ev[21:16], 1'b0, ev[15], ev[14:7], 1'b0, ev[6:0]};
  endfunction : uvec_usb_rank_map

  // Byte-lane merge of a write into an old word.
  function automatic logic [31:0] uvec_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : uvec_merge

endpackage : uvec_pkg

//--- core/uvec_prio_enc.sv
// Purpose: Lowest-index-first priority encoder.
// Assumes: Index zero is the best rank.
// Notes:   Combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module uvec_prio_enc #(
  parameter int W  = 32,
  parameter int IW = 5
) (
  input  wire logic [W-1:0]  req,
  output logic      [IW-1:0] idx,
  output logic               any
);

  if (W < 2 || (1 << IW) < W) begin : g_bad_size
    $error("uvec_prio_enc: W must be at least 2 and fit in IW bits.");
  end

  // Scan from the top so the lowest set index wins.
  always_comb begin
    idx = '0;
    any = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = IW'(i);
        any = 1'b1;
      end
    end
  end

endmodule : uvec_prio_enc
`default_nettype wire

//--- core/uvec_ctrl.sv
// Purpose: Sticky USB and FIFO event status with autovector substitution on jump fetches.
// Assumes: Event inputs are one-cycle pulses synchronous to ref_clk; the core holds
//          its fetch request for one cycle and takes the answer one cycle later.
// Notes:   Vectors are recomputed every cycle from the sticky status.
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module uvec_ctrl (
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire uvec_pkg::uvec_axi_req_t axi_req,
  output var  uvec_pkg::uvec_axi_rsp_t axi_rsp,
  input  wire logic [26:0]            usb_events,
  input  wire logic [13:0]            fifo_events,
  input  wire uvec_pkg::uvec_fetch_t  fetch,
  input  wire logic [7:0]             prog_byte,
  input  wire logic                   int_ack_usb,
  input  wire logic                   int_ack_fifo,
  output logic      [7:0]             fetch_byte_r,
  output logic                        fetch_done_r,
  output logic      [15:0]            branch_addr_r,
  output logic                        branch_valid_r,
  output logic                        usb_event_interrupt_r,
  output logic                        fifo_event_interrupt_r,
  output logic                        irq_r
);

  // Bus handshake state.
  logic        aw_rdy_r,  aw_rdy_nxt;
  logic        w_rdy_r,   w_rdy_nxt;
  logic        aw_held_r, aw_held_nxt;
  logic        w_held_r,  w_held_nxt;
  logic [7:0]  awaddr_r,  awaddr_nxt;
  logic [31:0] wdata_r,   wdata_nxt;
  logic [3:0]  wstrb_r,   wstrb_nxt;
  logic        bvalid_r,  bvalid_nxt;
  logic [1:0]  bresp_r,   bresp_nxt;
  logic        ar_rdy_r,  ar_rdy_nxt;
  logic        rvalid_r,  rvalid_nxt;
  logic [31:0] rdata_r,   rdata_nxt;
  logic [1:0]  rresp_r,   rresp_nxt;
  logic        wr_fire;

  // Register file state.
  logic [1:0]  interrupt_setup_register_r, interrupt_setup_register_nxt;
  logic [31:0] usb_en_r,   usb_en_nxt;
  logic [31:0] usb_stat_r, usb_stat_nxt;
  logic [13:0] fifo_en_r,   fifo_en_nxt;
  logic [13:0] fifo_stat_r, fifo_stat_nxt;
  logic [31:0] usb_clr;
  logic [13:0] fifo_clr;

  // Vector and core-facing state.
  logic [7:0]  usb_vector_byte_r,  usb_vector_byte_nxt;
  logic [7:0]  fifo_vector_byte_r, fifo_vector_byte_nxt;
  logic [4:0]  usb_idx;
  logic [3:0]  fifo_idx;
  logic        usb_any;
  logic        fifo_any;
  logic        usb_int_nxt;
  logic        fifo_int_nxt;
  logic [7:0]  fetch_byte_nxt;
  logic [15:0] branch_addr_nxt;
  logic        usb_autovector_enable;
  logic        fifo_autovector_enable;

  assign usb_autovector_enable  = interrupt_setup_register_r[uvec_pkg::SETUP_USB_AV];
  assign fifo_autovector_enable = interrupt_setup_register_r[uvec_pkg::SETUP_FIFO_AV];

  // Response fields come straight from registers.
  assign axi_rsp = '{awready: aw_rdy_r, wready: w_rdy_r, bvalid: bvalid_r, bresp: bresp_r,
                     arready: ar_rdy_r, rvalid: rvalid_r, rdata: rdata_r, rresp: rresp_r};

  // Write path: address and data are caught in either order; the update and
  // response follow once both are held. A second write waits for bready.
  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    wr_fire     = 1'b0;
    if (axi_req.awvalid && aw_rdy_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = axi_req.awaddr[7:0];
    end
    if (axi_req.wvalid && w_rdy_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt  = axi_req.wdata;
      wstrb_nxt  = axi_req.wstrb;
    end
    if (bvalid_r && axi_req.bready) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_held_nxt && w_held_nxt && !bvalid_r) begin
      wr_fire     = 1'b1;
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      unique case (awaddr_nxt)
        uvec_pkg::OFS_SETUP, uvec_pkg::OFS_USB_EN, uvec_pkg::OFS_USB_CLR,
        uvec_pkg::OFS_FIFO_EN, uvec_pkg::OFS_FIFO_CLR: bresp_nxt = uvec_pkg::RESP_OKAY;
        default: bresp_nxt = uvec_pkg::RESP_SLVERR;
      endcase
    end
    aw_rdy_nxt = !aw_held_nxt && !bvalid_nxt;
    w_rdy_nxt  = !w_held_nxt && !bvalid_nxt;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_rdy_r  <= 1'b0;
      w_rdy_r   <= 1'b0;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
    end else begin
      aw_rdy_r  <= aw_rdy_nxt;
      w_rdy_r   <= w_rdy_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
    end
  end

  // Read path: one read at a time, data one cycle after the address.
  always_comb begin
    ar_rdy_nxt = ar_rdy_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && axi_req.rready) begin
      rvalid_nxt = 1'b0;
    end
    if (axi_req.arvalid && ar_rdy_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = uvec_pkg::RESP_OKAY;
      unique case (axi_req.araddr[7:0])
        uvec_pkg::OFS_SETUP:     rdata_nxt = {30'h0000_0000, interrupt_setup_register_r};
        uvec_pkg::OFS_USB_STAT:  rdata_nxt = usb_stat_r;
        uvec_pkg::OFS_USB_EN:    rdata_nxt = usb_en_r;
        uvec_pkg::OFS_FIFO_STAT: rdata_nxt = {18'h0_0000, fifo_stat_r};
        uvec_pkg::OFS_FIFO_EN:   rdata_nxt = {18'h0_0000, fifo_en_r};
        uvec_pkg::OFS_VECTORS:   rdata_nxt = {16'h0000, fifo_vector_byte_r, usb_vector_byte_r};
        // Clear registers are write-only and read as zero.
        uvec_pkg::OFS_USB_CLR, uvec_pkg::OFS_FIFO_CLR: rdata_nxt = 32'h0000_0000;
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = uvec_pkg::RESP_SLVERR;
        end
      endcase
    end
    ar_rdy_nxt = !rvalid_nxt;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= 2'h0;
    end else begin
      ar_rdy_r <= ar_rdy_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end

  // Register file. An event beats a clear in the same cycle, so none is lost.
  always_comb begin
    interrupt_setup_register_nxt = interrupt_setup_register_r;
    usb_en_nxt  = usb_en_r;
    fifo_en_nxt = fifo_en_r;
    usb_clr     = 32'h0000_0000;
    fifo_clr    = 14'h0000;
    if (wr_fire) begin
      unique case (awaddr_nxt)
        uvec_pkg::OFS_SETUP:
          interrupt_setup_register_nxt = 2'(uvec_pkg::uvec_merge({30'h0000_0000, interrupt_setup_register_r},
                                                                 wdata_nxt, wstrb_nxt));
        uvec_pkg::OFS_USB_EN:   usb_en_nxt = uvec_pkg::uvec_merge(usb_en_r, wdata_nxt, wstrb_nxt)
                                             & uvec_pkg::USB_RANK_MASK;
        uvec_pkg::OFS_USB_CLR:  usb_clr = uvec_pkg::uvec_merge(32'h0000_0000, wdata_nxt, wstrb_nxt);
        uvec_pkg::OFS_FIFO_EN:  fifo_en_nxt = 14'(uvec_pkg::uvec_merge({18'h0_0000, fifo_en_r},
                                                                       wdata_nxt, wstrb_nxt));
        uvec_pkg::OFS_FIFO_CLR: fifo_clr = 14'(uvec_pkg::uvec_merge(32'h0000_0000, wdata_nxt, wstrb_nxt));
        default: ;
      endcase
    end
    usb_stat_nxt  = ((usb_stat_r & ~usb_clr) | uvec_pkg::uvec_usb_rank_map(usb_events))
                    & uvec_pkg::USB_RANK_MASK; // R1 R5 R7 R8
    fifo_stat_nxt = (fifo_stat_r & ~fifo_clr) | fifo_events; // R9
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      interrupt_setup_register_r <= uvec_pkg::SETUP_RST;
      usb_en_r    <= uvec_pkg::USB_EN_RST;
      fifo_en_r   <= uvec_pkg::FIFO_EN_RST;
      usb_stat_r  <= 32'h0000_0000;
      fifo_stat_r <= 14'h0000;
    end else begin
      interrupt_setup_register_r <= interrupt_setup_register_nxt;
      usb_en_r    <= usb_en_nxt;
      fifo_en_r   <= fifo_en_nxt;
      usb_stat_r  <= usb_stat_nxt;
      fifo_stat_r <= fifo_stat_nxt;
    end
  end

  // Best pending rank of each group.
  uvec_prio_enc #(.W(uvec_pkg::USB_RANKS), .IW(5)) u_usb_enc (
    .req (usb_stat_r),
    .idx (usb_idx),
    .any (usb_any)
  );

  uvec_prio_enc #(.W(uvec_pkg::FIFO_SRC), .IW(4)) u_fifo_enc (
    .req (fifo_stat_r),
    .idx (fifo_idx),
    .any (fifo_any)
  );

  // Vectors, request lines and the fetch answer. The vector is rank times four, so each
  // source gets its own four-byte slot of the page.
  always_comb begin
    usb_vector_byte_nxt  = usb_any ? (uvec_pkg::USB_VEC_BASE | {1'b0, usb_idx, 2'b00})
                                   : uvec_pkg::USB_VEC_BASE; // R4 R6 R14
    fifo_vector_byte_nxt = fifo_any ? (uvec_pkg::FIFO_VEC_BASE | {2'b00, fifo_idx, 2'b00})
                                    : uvec_pkg::FIFO_VEC_BASE; // R12 R13 R14
    usb_int_nxt  = |(usb_stat_r & usb_en_r); // R1
    fifo_int_nxt = |(fifo_stat_r & fifo_en_r); // R9
    fetch_byte_nxt = prog_byte; // R15
    if (fetch.valid && fetch.addr == uvec_pkg::USB_SUB_ADDR && usb_autovector_enable) begin
      fetch_byte_nxt = usb_vector_byte_r; // R3
    end else if (fetch.valid && fetch.addr == uvec_pkg::FIFO_SUB_ADDR && fifo_autovector_enable) begin
      fetch_byte_nxt = fifo_vector_byte_r; // R11
    end
    // USB entry wins if the core acknowledges both at once.
    branch_addr_nxt = branch_addr_r;
    if (int_ack_usb) begin
      branch_addr_nxt = uvec_pkg::USB_ENTRY; // R2
    end else if (int_ack_fifo) begin
      branch_addr_nxt = uvec_pkg::FIFO_ENTRY; // R10
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      usb_vector_byte_r      <= uvec_pkg::USB_VEC_BASE;
      fifo_vector_byte_r     <= uvec_pkg::FIFO_VEC_BASE;
      usb_event_interrupt_r  <= 1'b0;
      fifo_event_interrupt_r <= 1'b0;
      irq_r                  <= 1'b0;
      fetch_byte_r           <= 8'h00;
      fetch_done_r           <= 1'b0;
      branch_addr_r          <= 16'h0000;
      branch_valid_r         <= 1'b0;
    end else begin
      usb_vector_byte_r      <= usb_vector_byte_nxt;
      fifo_vector_byte_r     <= fifo_vector_byte_nxt;
      usb_event_interrupt_r  <= usb_int_nxt;
      fifo_event_interrupt_r <= fifo_int_nxt;
      irq_r                  <= usb_int_nxt | fifo_int_nxt;
      fetch_byte_r           <= fetch_byte_nxt;
      fetch_done_r           <= fetch.valid;
      branch_addr_r          <= branch_addr_nxt;
      branch_valid_r         <= int_ack_usb | int_ack_fifo;
    end
  end

  // Checks on the vector and interrupt behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence usb_sub_fetch_s;
    fetch.valid && fetch.addr == uvec_pkg::USB_SUB_ADDR && usb_autovector_enable;
  endsequence
  sequence fifo_sub_fetch_s;
    fetch.valid && fetch.addr == uvec_pkg::FIFO_SUB_ADDR && fifo_autovector_enable;
  endsequence

  usb_irq_raise_a: assert property ((usb_events[0] && usb_en_r[0] && usb_en_nxt[0])
    |-> ##2 usb_event_interrupt_r) else $error("USB request did not rise."); // R1
  usb_entry_a: assert property (int_ack_usb |=> branch_valid_r && branch_addr_r == 16'h0043)
    else $error("USB entry address wrong."); // R2
  usb_subst_a: assert property (usb_sub_fetch_s |=> fetch_done_r && fetch_byte_r == $past(usb_vector_byte_r))
    else $error("USB vector not substituted."); // R3
  usb_vec_form_a: assert property (usb_vector_byte_r[1:0] == 2'b00 && usb_vector_byte_r <= 8'h7C
    && usb_vector_byte_r != 8'h1C && usb_vector_byte_r != 8'h44) else $error("USB vector malformed."); // R4
  setup_code_a: assert property (usb_stat_r[0] |=> usb_vector_byte_r == 8'h00)
    else $error("Setup data code wrong."); // R5
  ep8_code_a: assert property (usb_stat_r == 32'h0000_8000 |=> usb_vector_byte_r == 8'h3C)
    else $error("Endpoint 8 buffer code wrong."); // R6
  nak_code_a: assert property (usb_stat_r == 32'h0001_0000 |=> usb_vector_byte_r == 8'h40)
    else $error("IN NAK code wrong."); // R7
  iso_code_a: assert property (usb_stat_r == 32'h1000_0000 |=> usb_vector_byte_r == 8'h70)
    else $error("Iso error code wrong."); // R8
  fifo_irq_raise_a: assert property ((fifo_events[13] && fifo_en_r[13] && fifo_en_nxt[13])
    |-> ##1 fifo_stat_r[13] ##1 fifo_event_interrupt_r && irq_r) else $error("FIFO request late."); // R9
  fifo_entry_a: assert property ((int_ack_fifo && !int_ack_usb) |=> branch_addr_r == 16'h0053)
    else $error("FIFO entry address wrong."); // R10
  fifo_subst_a: assert property (fifo_sub_fetch_s |=> fetch_byte_r == $past(fifo_vector_byte_r))
    else $error("FIFO vector not substituted."); // R11
  level_code_a: assert property (fifo_stat_r == 14'h0001 |=> fifo_vector_byte_r == 8'h80)
    else $error("Level flag code wrong."); // R12
  wave_code_a: assert property (fifo_stat_r == 14'h2000 |=> fifo_vector_byte_r == 8'hB4)
    else $error("Waveform event code wrong."); // R13
  best_rank_a: assert property ((usb_stat_r[3] && usb_stat_r[31] && usb_stat_r[2:0] == 3'b000)
    |=> usb_vector_byte_r == 8'h0C) else $error("Priority order wrong."); // R14
  pass_through_a: assert property ((fetch.valid && !usb_autovector_enable && !fifo_autovector_enable)
    |=> fetch_byte_r == $past(prog_byte)) else $error("Fetched byte altered."); // R15

endmodule : uvec_ctrl
`default_nettype wire

//--- test/uvec_core_model.sv
// Purpose: Core model that takes an interrupt and fetches its jump.
// Assumes: Program byte is the low address byte plus 0x30.
// Notes:   Three jump bytes are fetched back to back; the last is kept.
`timescale 1ns/1ps
`default_nettype none
module uvec_core_model (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             go_usb,
  input  wire logic             go_fifo,
  input  wire logic             branch_valid_r,
  input  wire logic [15:0]      branch_addr_r,
  input  wire logic             fetch_done_r,
  input  wire logic [7:0]       fetch_byte_r,
  output logic                  int_ack_usb,
  output logic                  int_ack_fifo,
  output var uvec_pkg::uvec_fetch_t fetch,
  output logic [7:0]            prog_byte,
  output logic [15:0]           entry,
  output logic [7:0]            sub_byte,
  output logic                  done
);
  logic [2:0]  step;
  logic [15:0] next_addr;

  // First fetch at the entry, the next two follow it.
  assign next_addr = branch_valid_r ? branch_addr_r : fetch.addr + 16'h0001;

  // Acknowledge, then opcode, page and low byte on successive edges.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_ack_usb  <= 1'b0;
      int_ack_fifo <= 1'b0;
      fetch        <= '0;
      prog_byte    <= 8'h00;
      entry        <= 16'h0000;
      sub_byte     <= 8'h00;
      done         <= 1'b0;
      step         <= 3'h0;
    end else begin
      int_ack_usb  <= go_usb;
      int_ack_fifo <= go_fifo;
      done         <= 1'b0;
      fetch.valid  <= 1'b0;
      prog_byte    <= ~prog_byte;  // An idle bus never shows a stale byte.
      if (branch_valid_r) begin
        entry <= branch_addr_r;
      end
      if (branch_valid_r || step == 3'h1 || step == 3'h2) begin
        fetch     <= '{valid: 1'b1, addr: next_addr};
        prog_byte <= next_addr[7:0] + 8'h30;
        step      <= step + 3'h1;
      end else if (step == 3'h3) begin
        step <= 3'h4;  // The last answer comes one edge later.
      end else if (step == 3'h4 && fetch_done_r) begin
        sub_byte <= fetch_byte_r;
        done     <= 1'b1;
        step     <= 3'h0;
      end
    end
  end
endmodule : uvec_core_model
`default_nettype wire

//--- test/usb_fifo_interrupt_autovector_bench.sv
// Purpose: Self-checking bench for the interrupt autovector block.
// Assumes: 25 MHz clock; the core model answers jump fetches.
// Notes:   Expected vectors come from the priority ranks.
`timescale 1ns/1ps
`default_nettype none
module usb_fifo_interrupt_autovector_bench;
  logic                    ref_clk = 1'b0;
  logic                    reset_n = 1'b0;
  uvec_pkg::uvec_axi_req_t req     = '0;
  uvec_pkg::uvec_axi_rsp_t rsp;
  uvec_pkg::uvec_fetch_t   fetch;
  logic [26:0]             usb_ev  = '0;
  logic [13:0]             fifo_ev = '0;
  logic                    go_usb  = 1'b0;
  logic                    go_fifo = 1'b0;
  logic [7:0]              prog_byte, fetch_byte, sub_byte;
  logic [15:0]             branch_addr, entry;
  logic                    ack_u, ack_f, f_done, b_valid, usb_irq, fifo_irq, irq, done;
  int                      fail_count = 0;
  int                      checked    = 0;

  uvec_ctrl i_uvec_ctrl (.ref_clk(ref_clk), .reset_n(reset_n), .axi_req(req), .axi_rsp(rsp),
    .usb_events(usb_ev), .fifo_events(fifo_ev), .fetch(fetch), .prog_byte(prog_byte),
    .int_ack_usb(ack_u), .int_ack_fifo(ack_f), .fetch_byte_r(fetch_byte), .fetch_done_r(f_done),
    .branch_addr_r(branch_addr), .branch_valid_r(b_valid), .usb_event_interrupt_r(usb_irq),
    .fifo_event_interrupt_r(fifo_irq), .irq_r(irq));
  uvec_core_model i_uvec_core_model (.ref_clk(ref_clk), .reset_n(reset_n), .go_usb(go_usb),
    .go_fifo(go_fifo), .branch_valid_r(b_valid), .branch_addr_r(branch_addr), .fetch_done_r(f_done),
    .fetch_byte_r(fetch_byte), .int_ack_usb(ack_u), .int_ack_fifo(ack_f), .fetch(fetch),
    .prog_byte(prog_byte), .entry(entry), .sub_byte(sub_byte), .done(done));

  // Free-running clock at 25 MHz.
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // Priority slot of a USB source bit; reserved slots are skipped.
  function automatic int rk(input int n);
    return n < 7 ? n : n < 15 ? n + 1 : n < 16 ? 16 : n < 22 ? n + 2 : n < 23 ? 24 : n + 5;
  endfunction : rk

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare

  // One AXI4-Lite transfer; each channel drops at the edge that takes it.
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    logic tk_aw, tk_w, tk_ar;
    logic fin = 1'b0;
    int   n = 0;
    @(posedge ref_clk);
    req.awaddr  <= {24'h0, a};
    req.araddr  <= {24'h0, a};
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.awvalid <= wr;
    req.wvalid  <= wr;
    req.bready  <= wr;
    req.arvalid <= !wr;
    req.rready  <= !wr;
    while (!fin && n < 50) begin
      @(negedge ref_clk);
      tk_aw = req.awvalid && rsp.awready;
      tk_w  = req.wvalid && rsp.wready;
      tk_ar = req.arvalid && rsp.arready;
      fin   = (req.bready && rsp.bvalid) || (req.rready && rsp.rvalid);
      q     = rsp.rdata;
      r     = wr ? rsp.bresp : rsp.rresp;
      n++;
      @(posedge ref_clk);
      if (tk_aw) req.awvalid <= 1'b0;
      if (tk_w) req.wvalid <= 1'b0;
      if (tk_ar) req.arvalid <= 1'b0;
      if (fin) req.bready <= 1'b0;
      if (fin) req.rready <= 1'b0;
    end
    if (!fin) fail_count++;
  endtask : axi

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  r;
    axi(1'b1, a, d, q, r);
    compare({30'h0, r}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  r;
    axi(1'b0, a, 32'h0, q, r);
    compare(q, e);
    compare({30'h0, r}, {30'h0, er});
  endtask : rd

  // One-cycle event pulse, then three edges to settle.
  task automatic pulse(input logic [26:0] u, input logic [13:0] f);
    @(posedge ref_clk);
    usb_ev  <= u;
    fifo_ev <= f;
    @(posedge ref_clk);
    usb_ev  <= '0;
    fifo_ev <= '0;
    repeat (3) @(posedge ref_clk);
  endtask : pulse

  // The core takes the interrupt; entry and low byte are judged.
  task automatic vector_fetch(input logic f, input logic [15:0] e_entry, input logic [7:0] e_byte);
    int n = 0;
    @(posedge ref_clk);
    go_usb  <= !f;
    go_fifo <= f;
    @(posedge ref_clk);
    go_usb  <= 1'b0;
    go_fifo <= 1'b0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 20) fail_count++;
    compare({16'h0, entry}, {16'h0, e_entry});
    compare({24'h0, sub_byte}, {24'h0, e_byte});
  endtask : vector_fetch

  // A lone source: status bit, interrupt lines, vector fetch, then clear.
  task automatic one_source(input logic f, input int n);
    logic [31:0] bitv;
    bitv = f ? 32'h1 << n : 32'h1 << rk(n);
    pulse(f ? 27'h0 : 27'h1 << n, f ? 14'h1 << n : 14'h0);
    compare({30'h0, irq, f ? fifo_irq : usb_irq}, 32'h3);
    rd(f ? 8'h10 : 8'h04, bitv, 2'h0);
    vector_fetch(f, f ? 16'h0053 : 16'h0043, f ? 8'h80 + 8'(4 * n) : 8'(4 * rk(n)));
    wr(f ? 8'h18 : 8'h0C, bitv, 2'h0);
    repeat (3) @(posedge ref_clk);
    compare({31'h0, irq}, 32'h0);
  endtask : one_source

  task automatic t_registers;
    logic [31:0] mask = 32'h0;
    for (int n = 0; n < 27; n++) mask |= 32'h1 << rk(n);
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    rd(8'h1C, 32'h0000_8000, 2'h0);
    wr(8'h04, 32'hFFFF_FFFF, 2'h2);
    rd(8'h24, 32'h0, 2'h2);
    rd(8'h0C, 32'h0, 2'h0);
    wr(8'h08, 32'hFFFF_FFFF, 2'h0);
    rd(8'h08, mask, 2'h0);
    wr(8'h14, 32'h0000_3FFF, 2'h0);
    rd(8'h14, 32'h0000_3FFF, 2'h0);
    wr(8'h00, 32'h0000_0003, 2'h0);
  endtask : t_registers

  task automatic t_usb_codes;
    for (int n = 0; n < 27; n++) one_source(1'b0, n);
  endtask : t_usb_codes

  task automatic t_fifo_codes;
    for (int n = 0; n < 14; n++) one_source(1'b1, n);
  endtask : t_fifo_codes

  // Several pending: the best rank wins, the next after a clear.
  task automatic t_priority;
    pulse(27'h400_0208, 14'h2020);
    rd(8'h1C, 32'h0000_940C, 2'h0);
    wr(8'h0C, 32'h0000_0008, 2'h0);
    repeat (3) @(posedge ref_clk);
    rd(8'h1C, 32'h0000_9428, 2'h0);
    vector_fetch(1'b0, 16'h0043, 8'h28);
    wr(8'h0C, 32'hFFFF_FFFF, 2'h0);
    wr(8'h18, 32'h0000_3FFF, 2'h0);
  endtask : t_priority

  // Autovector off passes program bytes; a disabled source stays masked.
  task automatic t_passthrough;
    wr(8'h00, 32'h0, 2'h0);
    wr(8'h08, 32'h0, 2'h0);
    pulse(27'h10, 14'h1);
    compare({31'h0, usb_irq}, 32'h0);
    vector_fetch(1'b0, 16'h0043, 8'h75);
    vector_fetch(1'b1, 16'h0053, 8'h85);
    wr(8'h08, 32'h0000_0010, 2'h0);
    repeat (3) @(posedge ref_clk);
    compare({31'h0, usb_irq}, 32'h1);
    wr(8'h18, 32'h0000_0001, 2'h0);
  endtask : t_passthrough

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // Main sequence after a 20-cycle reset.
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_registers();
    t_usb_codes();
    t_fifo_codes();
    t_priority();
    t_passthrough();
    summarize();
  end

  // A hang is caught after 50000 cycles.
  initial begin
    #2000000;
    fail_count++;
    summarize();
  end
endmodule : usb_fifo_interrupt_autovector_bench
`default_nettype wire
